// [verilog/amx_pkg.sv]
// amx_pkg: register map, field positions and timing for the alert mask / config slice
package amx_pkg;

  // register offsets on the documented register port
  localparam logic [7:0] OFS_ALERT_MASK_TWO  = 8'h75;
  localparam logic [7:0] OFS_EXT_LOW_ONE     = 8'h76;
  localparam logic [7:0] OFS_EXT_LOW_TWO     = 8'h77;
  localparam logic [7:0] OFS_PIN_TACH_CONFIG = 8'h78;

  // power-on values
  localparam logic [7:0] RST_ALERT_MASK_TWO  = 8'h00;
  localparam logic [7:0] RST_EXT_LOW         = 8'h00;
  localparam logic [7:0] RST_PIN_TACH_CONFIG = 8'h00;
  localparam logic [7:0] READ_UNMAPPED       = 8'h00;

  // alert mask fields
  localparam int MSK_TWELVE_VOLT_OR_VID = 0;
  localparam int MSK_OVERTEMP           = 1;
  localparam int MSK_FAN1               = 2;
  localparam int MSK_FAN2               = 3;
  localparam int MSK_FAN3               = 4;
  localparam int MSK_FAN4_OR_TIMER      = 5;
  localparam int MSK_REMOTE_ONE_DIODE   = 6;
  localparam int MSK_REMOTE_TWO_DIODE   = 7;

  // configuration fields
  localparam int CFG_ALERT_ENABLE       = 0;
  localparam int CFG_THERMAL_ROUTING    = 1;
  localparam int CFG_FULL_FAN_ON_THERMAL_LIMIT_PIN  = 2;
  localparam int CFG_FAST_TACH          = 3;
  localparam int CFG_CONT_TACH_LO       = 4;
  localparam int CFG_CONT_TACH_HI       = 7;

  // shared pin function codes
  localparam logic [1:0] FN_FOURTH_TACH = 2'h0;
  localparam logic [1:0] FN_THERMAL     = 2'h1;
  localparam logic [1:0] FN_ALERT       = 2'h2;
  localparam logic [1:0] FN_GENERAL_IO  = 2'h3;

  // fast tach repeat time
  localparam int FAST_TACH_MS     = 250;
  localparam int CLK_KHZ          = 200000;
  localparam int FAST_TACH_CYCLES = FAST_TACH_MS * CLK_KHZ;

endpackage : amx_pkg

// [verilog/amx_cap_if.sv]
// amx_cap_if: carries one extended-resolution capture channel between top and capture
`timescale 1ns/1ps
`default_nettype none
interface amx_cap_if;
  logic       update;
  logic [7:0] low_bits;
  logic       ext_read;
  logic [3:0] hi_read;
  logic       frozen;
  logic [7:0] held;

  modport owner   (output update, low_bits, ext_read, hi_read, input frozen, held);
  modport capture (input update, low_bits, ext_read, hi_read, output frozen, held);
endinterface : amx_cap_if
`default_nettype wire

// [verilog/amx_low_capture.sv]
// amx_low_capture: low-bit readback register that freezes on read until high bytes are read
`timescale 1ns/1ps
`default_nettype none
module amx_low_capture (
  // clock and reset
  input wire logic     core_clk_i,
  input wire logic     reset_n_i,
  // capture channel
  amx_cap_if.capture   cap
);

  logic       frozen_reg, frozen_next;
  logic [7:0] held_reg,   held_next;
  logic [3:0] seen_reg,   seen_next;

  // a fresh read re-arms the freeze even if the last high byte lands in that cycle
  always_comb begin
    frozen_next = frozen_reg;
    seen_next   = frozen_reg ? (seen_reg | cap.hi_read) : 4'h0;
    held_next   = held_reg;
    if (cap.ext_read) begin
      frozen_next = 1'b1;
      seen_next   = 4'h0;
    end else if (frozen_reg && (&(seen_reg | cap.hi_read))) begin
      frozen_next = 1'b0;
      seen_next   = 4'h0;
    end
    // no update during a read so the low bits match the high bytes frozen with them
    if (cap.update && !frozen_reg && !cap.ext_read) begin
      held_next = cap.low_bits;
    end
  end

  // state registers
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      frozen_reg <= 1'b0;
      seen_reg   <= 4'h0;
      held_reg   <= amx_pkg::RST_EXT_LOW;
    end else begin
      frozen_reg <= frozen_next;
      seen_reg   <= seen_next;
      held_reg   <= held_next;
    end
  end

  assign cap.frozen = frozen_reg;
  assign cap.held   = held_reg;

  chk_freeze_on_read: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cap.ext_read |=> frozen_reg) else $error("read did not freeze low bits");

  chk_frozen_holds: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (frozen_reg && !(&(seen_reg | cap.hi_read))) |=> $stable(held_reg) && frozen_reg)
    else $error("frozen low bits changed");

endmodule : amx_low_capture
`default_nettype wire

// [verilog/amx_tick_gen.sv]
// amx_tick_gen: periodic one-cycle tick while enabled
`timescale 1ns/1ps
`default_nettype none
module amx_tick_gen #(
  parameter int PERIOD = amx_pkg::FAST_TACH_CYCLES
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic reset_n_i,
  // control and tick
  input  wire logic enable_i,
  output logic      tick_o
);

  logic [31:0] count_reg, count_next;
  logic        tick_reg,  tick_next;

  // counter restarts whenever the mode is off, so the first tick is a full period away
  always_comb begin
    count_next = 32'h0;
    tick_next  = 1'b0;
    if (enable_i) begin
      if (count_reg == 32'(PERIOD - 1)) begin
        tick_next = 1'b1;
      end else begin
        count_next = count_reg + 32'h1;
      end
    end
  end

  // state registers
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      count_reg <= 32'h0;
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

  assign tick_o = tick_reg;

  chk_tick_spacing: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    tick_reg |-> count_reg == 32'h0) else $error("tick with counter not restarted");

endmodule : amx_tick_gen
`default_nettype wire

// [verilog/amx_regs.sv]
// amx_regs: alert mask, extended-resolution readback and pin/tach configuration registers
//
// Summary of operation
// - mask bit 0 hides 12 V alerts
// - as voltage-ID pin, bit 0 hides code-change alerts
// - mask bit 1 hides thermal-pin overtemperature alerts
// - mask bits 2-4 hide fan 1-3 faults
// - mask bit 5 meaning follows shared pin function
// - mask bits 6-7 hide remote diode faults
// - all four registers reset to zero
// - first readback: 2.5 V, Vccp, Vcc, 5 V
// - second readback: 12 V, remote1, local, remote2
// - readback read freezes it and high bytes
// - config bit 0 picks alert or fan drive
// - routing bit and code place thermal input
// - fast bit repeats tach every 250 ms
// - bits 4-7 continuous tach, no stretching
// - lock bit makes configuration read-only
// - timer overrun sets status bit 5, masked
`timescale 1ns/1ps
`default_nettype none
module amx_regs #(
  parameter int FAST_TACH_CYCLES = amx_pkg::FAST_TACH_CYCLES
) (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  // register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_hit_o,
  // lock from the first configuration register
  input  wire logic       config_lock_i,
  // second interrupt status register contents
  input  wire logic [7:0] status_two_i,
  input  wire logic       voltage_id_bit_five_mode_i,
  // measurement low bits and high-byte read strobes
  input  wire logic       meas_update_i,
  input  wire logic [7:0] low_bits_one_i,
  input  wire logic [7:0] low_bits_two_i,
  input  wire logic [3:0] hi_read_one_i,
  input  wire logic [3:0] hi_read_two_i,
  output logic            frozen_one_o,
  output logic            frozen_two_o,
  // shared pins
  input  wire logic [1:0] shared_pin_function_code_i,
  input  wire logic       pin22_level_n_i,
  input  wire logic       pin14_level_n_i,
  input  wire logic       second_fan_drive_i,
  output logic            pin10_out_o,
  output logic            pin10_oe_n_o,
  output logic            pin14_out_o,
  output logic            pin14_oe_n_o,
  // pin routing decode
  output logic            pin22_thermal_o,
  output logic            pin14_fourth_tach_o,
  output logic            pin14_thermal_o,
  output logic            pin14_general_io_o,
  output logic            thermal_limit_pin_o,
  // fan and tach controls
  output logic            fans_full_o,
  output logic            fast_tach_o,
  output logic            fast_tach_tick_o,
  output logic      [3:0] continuous_tach_o,
  output logic      [3:0] stretch_disable_o,
  // alert level
  output logic            alert_active_o
);

  logic [7:0] mask_reg,   mask_next;
  logic [7:0] cfg_reg,    cfg_next;
  logic [7:0] rdata_reg,  rdata_next;
  logic       alert_reg,  alert_next;
  logic       p10_out_reg, p10_out_next;
  logic       p10_oe_reg,  p10_oe_next;
  logic       p14_oe_reg,  p14_oe_next;
  logic       full_reg,   full_next;
  logic       hit_mask, hit_ext1, hit_ext2, hit_cfg;
  logic       pin22_thermal_limit_pin, pin14_thermal_limit_pin, thermal_limit_pin_on;

  amx_cap_if cap_one ();
  amx_cap_if cap_two ();

  // address decode
  always_comb begin
    hit_mask = 1'b0;
    hit_ext1 = 1'b0;
    hit_ext2 = 1'b0;
    hit_cfg  = 1'b0;
    if (reg_addr_i == amx_pkg::OFS_ALERT_MASK_TWO) begin
      hit_mask = 1'b1;
    end else if (reg_addr_i == amx_pkg::OFS_EXT_LOW_ONE) begin
      hit_ext1 = 1'b1;
    end else if (reg_addr_i == amx_pkg::OFS_EXT_LOW_TWO) begin
      hit_ext2 = 1'b1;
    end else if (reg_addr_i == amx_pkg::OFS_PIN_TACH_CONFIG) begin
      hit_cfg = 1'b1;
    end
  end

  assign reg_hit_o = hit_mask | hit_ext1 | hit_ext2 | hit_cfg;

  // capture channels; the readback registers take no writes
  assign cap_one.update   = meas_update_i;
  assign cap_one.low_bits = low_bits_one_i;
  assign cap_one.ext_read = reg_rd_i && hit_ext1;
  assign cap_one.hi_read  = hi_read_one_i;
  assign cap_two.update   = meas_update_i;
  assign cap_two.low_bits = low_bits_two_i;
  assign cap_two.ext_read = reg_rd_i && hit_ext2;
  assign cap_two.hi_read  = hi_read_two_i;

  amx_low_capture u_cap_one (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .cap        (cap_one.capture)
  );

  amx_low_capture u_cap_two (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .cap        (cap_two.capture)
  );

  // frozen flags also hold the matching high-byte result registers outside
  assign frozen_one_o = cap_one.frozen;
  assign frozen_two_o = cap_two.frozen;

  // writes and read data
  always_comb begin
    mask_next  = mask_reg;
    cfg_next   = cfg_reg;
    rdata_next = rdata_reg;
    if (reg_wr_i && hit_mask) begin
      mask_next = reg_wdata_i;
    end
    // once locked, writes are dropped silently
    if (reg_wr_i && hit_cfg && !config_lock_i) begin
      cfg_next = reg_wdata_i;
    end
    if (reg_rd_i) begin
      if (hit_mask) begin
        rdata_next = mask_reg;
      end else if (hit_ext1) begin
        rdata_next = cap_one.held;
      end else if (hit_ext2) begin
        rdata_next = cap_two.held;
      end else if (hit_cfg) begin
        rdata_next = cfg_reg;
      end else begin
        rdata_next = amx_pkg::READ_UNMAPPED;
      end
    end
  end

  // pin routing: pin 22 is thermal only when routed there and pin 14 is not thermal
  always_comb begin
    pin22_thermal_limit_pin = cfg_reg[amx_pkg::CFG_THERMAL_ROUTING] &&
                  (shared_pin_function_code_i != amx_pkg::FN_THERMAL);
    pin14_thermal_limit_pin = (shared_pin_function_code_i == amx_pkg::FN_THERMAL);
    thermal_limit_pin_on    = (pin22_thermal_limit_pin && !pin22_level_n_i) ||
                  (pin14_thermal_limit_pin && !pin14_level_n_i);
  end

  assign pin22_thermal_o     = pin22_thermal_limit_pin;
  assign pin14_thermal_o     = pin14_thermal_limit_pin;
  assign pin14_fourth_tach_o = (shared_pin_function_code_i == amx_pkg::FN_FOURTH_TACH);
  assign pin14_general_io_o  = (shared_pin_function_code_i == amx_pkg::FN_GENERAL_IO);
  assign thermal_limit_pin_o = thermal_limit_pin_on;

  // alert and pin drive
  always_comb begin
    // masks gate the alert only; status bits stay untouched for software
    // bit 0 is 12 V or voltage-ID change, bit 5 follows the pin 14 function
    alert_next = |(status_two_i & ~mask_reg);
    full_next  = cfg_reg[amx_pkg::CFG_FULL_FAN_ON_THERMAL_LIMIT_PIN] && thermal_limit_pin_on;
    if (cfg_reg[amx_pkg::CFG_ALERT_ENABLE]) begin
      // open drain: pull low only while an alert is pending
      p10_out_next = 1'b0;
      p10_oe_next  = !alert_reg;
    end else begin
      p10_out_next = second_fan_drive_i;
      p10_oe_next  = 1'b0;
    end
    p14_oe_next = !(alert_reg && (shared_pin_function_code_i == amx_pkg::FN_ALERT));
  end

  // state registers
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      mask_reg    <= amx_pkg::RST_ALERT_MASK_TWO;
      cfg_reg     <= amx_pkg::RST_PIN_TACH_CONFIG;
      rdata_reg   <= amx_pkg::READ_UNMAPPED;
      alert_reg   <= 1'b0;
      p10_out_reg <= 1'b0;
      p10_oe_reg  <= 1'b1;
      p14_oe_reg  <= 1'b1;
      full_reg    <= 1'b0;
    end else begin
      mask_reg    <= mask_next;
      cfg_reg     <= cfg_next;
      rdata_reg   <= rdata_next;
      alert_reg   <= alert_next;
      p10_out_reg <= p10_out_next;
      p10_oe_reg  <= p10_oe_next;
      p14_oe_reg  <= p14_oe_next;
      full_reg    <= full_next;
    end
  end

  assign reg_rdata_o    = rdata_reg;
  assign alert_active_o = alert_reg;
  assign pin10_out_o    = p10_out_reg;
  assign pin10_oe_n_o   = p10_oe_reg;
  assign pin14_out_o    = 1'b0;
  assign pin14_oe_n_o   = p14_oe_reg;
  assign fans_full_o    = full_reg;

  // tach controls straight from the configuration register
  assign fast_tach_o       = cfg_reg[amx_pkg::CFG_FAST_TACH];
  assign continuous_tach_o = cfg_reg[amx_pkg::CFG_CONT_TACH_HI:amx_pkg::CFG_CONT_TACH_LO];
  assign stretch_disable_o = cfg_reg[amx_pkg::CFG_CONT_TACH_HI:amx_pkg::CFG_CONT_TACH_LO];

  // fast tach repeat tick; long count, so the period is a parameter
  amx_tick_gen #(
    .PERIOD (FAST_TACH_CYCLES)
  ) u_fast_tick (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .enable_i   (cfg_reg[amx_pkg::CFG_FAST_TACH]),
    .tick_o     (fast_tach_tick_o)
  );

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_reset_zero: assert property ($rose(reset_n_i) |->
    mask_reg == 8'h00 && cfg_reg == 8'h00) else $error("registers not zero after reset");

  chk_lock_blocks: assert property ((reg_wr_i && hit_cfg && config_lock_i) |=>
    $stable(cfg_reg)) else $error("locked configuration changed");

  chk_mask_write: assert property ((reg_wr_i && hit_mask) |=>
    mask_reg == $past(reg_wdata_i)) else $error("mask write lost");

  chk_alert_gate: assert property (##1 alert_reg ==
    |($past(status_two_i) & ~$past(mask_reg))) else $error("alert not status and not mask");

  chk_pin10_alert: assert property ((cfg_reg[amx_pkg::CFG_ALERT_ENABLE] && alert_reg) |=>
    (!pin10_oe_n_o && !pin10_out_o) ||
    !$past(cfg_reg[amx_pkg::CFG_ALERT_ENABLE])) else $error("alert pin not low");

  chk_pin10_drive: assert property ((!cfg_reg[amx_pkg::CFG_ALERT_ENABLE]) |=>
    !pin10_oe_n_o && pin10_out_o == $past(second_fan_drive_i)) else $error("fan drive lost");

  chk_full_fan_on_thermal_fans: assert property ((cfg_reg[amx_pkg::CFG_FULL_FAN_ON_THERMAL_LIMIT_PIN] && thermal_limit_pin_on) |=>
    fans_full_o) else $error("full_fan_on_thermal did not force full fans");

  chk_pin22_route: assert property ((shared_pin_function_code_i == amx_pkg::FN_THERMAL) |->
    !pin22_thermal_o) else $error("pin 22 thermal with pin 14 thermal");

  chk_ext_read: assert property ((reg_rd_i && hit_ext2) |=>
    reg_rdata_o == $past(cap_two.held)) else $error("readback two wrong");

endmodule : amx_regs
`default_nettype wire

// [verif/amx_host_model.sv]
// amx_host_model: register-port host that writes and reads the slice with random idle gaps
`timescale 1ns/1ps
`default_nettype none
module amx_host_model (
  // clock
  input  wire logic       core_clk_i,
  // register port towards the slice
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i
);
  // idle port at time zero
  initial begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o    = 1'b0;
  end

  // one-cycle write strobe; data inverted after release so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    repeat ($urandom_range(2)) @(posedge core_clk_i);
    @(posedge core_clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= dat;
    reg_wr_o    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_o    <= 1'b0;
    reg_wdata_o <= ~dat;
  endtask : wr

  // one-cycle read strobe; data is taken one edge later, where the registered answer stands
  task automatic rd(input logic [7:0] a, output logic [7:0] dat);
    repeat ($urandom_range(2)) @(posedge core_clk_i);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_o   <= 1'b0;
    // answer was launched at the previous edge and holds until the next read
    @(posedge core_clk_i);
    dat = reg_rdata_i;
  endtask : rd
endmodule : amx_host_model
`default_nettype wire

// [verif/amx_regs_tb_top.sv]
// amx_regs_tb_top: self-checking bench for the alert mask / readback / config slice
`timescale 1ns/1ps
`default_nettype none
module amx_regs_tb_top;
  logic       core_clk_i, reset_n_i, reg_wr_i, reg_rd_i, reg_hit_o, config_lock_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, status_two_i;
  logic [7:0] low_bits_one_i, low_bits_two_i;
  logic [3:0] hi_read_one_i, hi_read_two_i, continuous_tach_o, stretch_disable_o;
  logic [1:0] shared_pin_function_code_i;
  logic       voltage_id_bit_five_mode_i, meas_update_i, frozen_one_o, frozen_two_o;
  logic       pin22_level_n_i, pin14_level_n_i, second_fan_drive_i;
  logic       pin10_out_o, pin10_oe_n_o, pin14_out_o, pin14_oe_n_o, pin22_thermal_o;
  logic       pin14_fourth_tach_o, pin14_thermal_o, pin14_general_io_o, thermal_limit_pin_o;
  logic       fans_full_o, fast_tach_o, fast_tach_tick_o, alert_active_o;
  int         failures, comparisons, n, k, ticks, seed;
  logic [7:0] d, v, mdl_mask, mdl_cfg;
  logic [7:0] mdl_low [2];

  // short tick period keeps the fast tach check brief
  amx_regs #(.FAST_TACH_CYCLES(8)) amx_regs_inst (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o), .config_lock_i(config_lock_i),
    .status_two_i(status_two_i), .voltage_id_bit_five_mode_i(voltage_id_bit_five_mode_i),
    .meas_update_i(meas_update_i), .low_bits_one_i(low_bits_one_i),
    .low_bits_two_i(low_bits_two_i), .hi_read_one_i(hi_read_one_i),
    .hi_read_two_i(hi_read_two_i), .frozen_one_o(frozen_one_o), .frozen_two_o(frozen_two_o),
    .shared_pin_function_code_i(shared_pin_function_code_i),
    .pin22_level_n_i(pin22_level_n_i), .pin14_level_n_i(pin14_level_n_i),
    .second_fan_drive_i(second_fan_drive_i), .pin10_out_o(pin10_out_o),
    .pin10_oe_n_o(pin10_oe_n_o), .pin14_out_o(pin14_out_o), .pin14_oe_n_o(pin14_oe_n_o),
    .pin22_thermal_o(pin22_thermal_o), .pin14_fourth_tach_o(pin14_fourth_tach_o),
    .pin14_thermal_o(pin14_thermal_o), .pin14_general_io_o(pin14_general_io_o),
    .thermal_limit_pin_o(thermal_limit_pin_o), .fans_full_o(fans_full_o),
    .fast_tach_o(fast_tach_o), .fast_tach_tick_o(fast_tach_tick_o),
    .continuous_tach_o(continuous_tach_o), .stretch_disable_o(stretch_disable_o),
    .alert_active_o(alert_active_o)
  );

  amx_host_model amx_host_model_inst (
    .core_clk_i(core_clk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
    .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o)
  );

  // 200 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // fan drive level wanders so the pwm path is never static
  always @(posedge core_clk_i) begin
    second_fan_drive_i <= 1'($urandom);
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // new low bits on both channels in one update pulse
  task automatic upd(input logic [7:0] x);
    @(posedge core_clk_i);
    low_bits_one_i <= x;
    low_bits_two_i <= ~x;
    meas_update_i  <= 1'b1;
    @(posedge core_clk_i);
    meas_update_i  <= 1'b0;
  endtask : upd

  // high-byte read strobes for one channel
  task automatic hir(input int ch, input logic [3:0] b);
    @(posedge core_clk_i);
    if (ch == 0) hi_read_one_i <= b;
    else hi_read_two_i <= b;
    @(posedge core_clk_i);
    hi_read_one_i <= 4'h0;
    hi_read_two_i <= 4'h0;
  endtask : hir

  // hang guard: a bounded run that ends in the closing report
  initial begin
    repeat (20000) @(posedge core_clk_i);
    failures++;
    $display("ERROR run_length expected finish seen timeout");
    final_report();
  end

  initial begin
    seed = $urandom(32'ha93ade89);
    {reset_n_i, config_lock_i, meas_update_i, voltage_id_bit_five_mode_i} = 4'h0;
    {status_two_i, low_bits_one_i, low_bits_two_i} = 24'h0;
    {hi_read_one_i, hi_read_two_i, shared_pin_function_code_i} = 10'h0;
    {pin22_level_n_i, pin14_level_n_i} = 2'h3;
    repeat (5) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    // power-on values, then one unmapped address
    for (n = 0; n < 5; n++) begin
      amx_host_model_inst.rd(8'h75 + 8'(n), d);
      chk("reg_reset", d, 8'h00);
    end
    chk("hit_unmapped", {7'h0, reg_hit_o}, 8'h00);
    $display("test reset_values done");
    // alert mode on pin 10 and pin 14 so the open-drain pins follow the alert
    shared_pin_function_code_i <= amx_pkg::FN_ALERT;
    amx_host_model_inst.wr(amx_pkg::OFS_PIN_TACH_CONFIG, 8'h01);
    // single and random fault sources against random masks
    for (n = 0; n < 16; n++) begin
      mdl_mask = 8'($urandom);
      amx_host_model_inst.wr(amx_pkg::OFS_ALERT_MASK_TWO, mdl_mask);
      @(posedge core_clk_i);
      v = (n < 8) ? (8'h01 << n) : 8'($urandom);
      status_two_i <= v;
      voltage_id_bit_five_mode_i <= n[0];
      @(posedge core_clk_i);
      #1;
      chk("alert", {7'h0, alert_active_o}, {7'h0, |(v & ~mdl_mask)});
      amx_host_model_inst.rd(amx_pkg::OFS_ALERT_MASK_TWO, d);
      chk("mask", d, mdl_mask);
      chk("alert_pins", {4'h0, pin14_out_o, pin14_oe_n_o, pin10_out_o, pin10_oe_n_o},
          {5'h0, !(|(v & ~mdl_mask)), 1'b0, !(|(v & ~mdl_mask))});
    end
    status_two_i <= 8'h00;
    $display("test alert_mask done");
    // every routing bit and function code, with random mode bits
    for (n = 0; n < 8; n++) begin
      v = 8'($urandom);
      mdl_cfg = {v[7:2], n[2], v[0]};
      shared_pin_function_code_i <= n[1:0];
      amx_host_model_inst.wr(amx_pkg::OFS_PIN_TACH_CONFIG, mdl_cfg);
      amx_host_model_inst.rd(amx_pkg::OFS_PIN_TACH_CONFIG, d);
      chk("config", d, mdl_cfg);
      chk("tach_modes", {continuous_tach_o, stretch_disable_o}, {2{mdl_cfg[7:4]}});
      chk("pin_decode", {2'h0, pin10_oe_n_o, fast_tach_o, pin22_thermal_o,
          pin14_fourth_tach_o, pin14_thermal_o, pin14_general_io_o},
          {2'h0, mdl_cfg[0], mdl_cfg[3], mdl_cfg[1] && n[1:0] != 2'h1,
          n[1:0] == 2'h0, n[1:0] == 2'h1, n[1:0] == 2'h3});
    end
    config_lock_i <= 1'b1;
    amx_host_model_inst.wr(amx_pkg::OFS_PIN_TACH_CONFIG, ~mdl_cfg);
    amx_host_model_inst.rd(amx_pkg::OFS_PIN_TACH_CONFIG, d);
    chk("config_locked", d, mdl_cfg);
    config_lock_i <= 1'b0;
    $display("test config_lock done");
    // readback freeze on each channel, with writes refused
    for (n = 0; n < 2; n++) begin
      hir(0, 4'hf);
      hir(1, 4'hf);
      v = 8'($urandom);
      upd(v);
      mdl_low[0] = v;
      mdl_low[1] = ~v;
      amx_host_model_inst.wr(8'h76 + 8'(n), 8'hff);
      amx_host_model_inst.rd(8'h76 + 8'(n), d);
      chk("low_bits", d, mdl_low[n]);
      chk("frozen", {6'h0, frozen_two_o, frozen_one_o}, 8'h01 << n);
      upd(~v ^ 8'h5a);
      amx_host_model_inst.rd(8'h76 + 8'(n), d);
      chk("low_held", d, mdl_low[n]);
      for (k = 0; k < 3; k++) hir(n, 4'h1 << k);
      #1;
      chk("still_frozen", {6'h0, frozen_two_o, frozen_one_o}, 8'h01 << n);
      hir(n, 4'h8);
      for (k = 0; k < 3 && (frozen_one_o | frozen_two_o); k++) @(posedge core_clk_i);
      #1;
      chk("released", {6'h0, frozen_two_o, frozen_one_o}, 8'h00);
      v = 8'($urandom);
      upd(v);
      amx_host_model_inst.rd(8'h76 + 8'(n), d);
      chk("low_fresh", d, n == 0 ? v : ~v);
    end
    hir(0, 4'hf);
    hir(1, 4'hf);
    $display("test readback_freeze done");
    // fast tach period, then off
    for (n = 0; n < 2; n++) begin
      amx_host_model_inst.wr(amx_pkg::OFS_PIN_TACH_CONFIG, n == 0 ? 8'h08 : 8'h00);
      repeat (4) @(posedge core_clk_i);
      ticks = 0;
      for (k = 0; k < 32; k++) begin
        @(posedge core_clk_i);
        #1;
        ticks += int'(fast_tach_tick_o === 1'b1);
      end
      chk("tick_count", 8'(ticks), n == 0 ? 8'h04 : 8'h00);
    end
    $display("test fast_tach done");
    // thermal on pin 14 with full_fan_on_thermal off and on
    @(posedge core_clk_i);
    shared_pin_function_code_i <= amx_pkg::FN_THERMAL;
    for (n = 0; n < 2; n++) begin
      amx_host_model_inst.wr(amx_pkg::OFS_PIN_TACH_CONFIG, n == 0 ? 8'h00 : 8'h04);
      @(posedge core_clk_i);
      pin14_level_n_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      #1;
      chk("full_fan_on_thermal", {6'h0, thermal_limit_pin_o, fans_full_o}, {6'h0, 1'b1, n[0]});
      @(posedge core_clk_i);
      pin14_level_n_i <= 1'b1;
    end
    $display("test full_fan_on_thermal done");
    final_report();
  end
endmodule : amx_regs_tb_top
`default_nettype wire
